// ---- core/wft_consts.svh ----
// constants for the watchdog feed timer: keys, field positions, resets
`ifndef WFT_CONSTS_SVH
`define WFT_CONSTS_SVH

// feed sequence keys
`define WFT_FEED1_KEY   8'hA5
`define WFT_FEED2_KEY   8'h5A

// control byte field positions
`define WFT_SEL_MSB     7
`define WFT_SEL_LSB     5
`define WFT_RUN_BIT     2
`define WFT_TOF_BIT     1

// widths
`define WFT_PRESC_W     13
`define WFT_COUNT_W     8
`define WFT_SEL_W       3

// lowest prescaler bit index of the tap window (code 0 = divide by 32)
`define WFT_TAP_BASE    4

// reset values
`define WFT_CTRL_RST    8'hE4
`define WFT_SEL_RST     3'h7
`define WFT_RELOAD_RST  8'h00
`define WFT_PRESC_RST   13'h0000

`endif

// ---- core/wft_pkg.sv ----
// types shared by the watchdog feed timer
package wft_pkg;

  // which special function register a bus access targets
  typedef enum logic [2:0] {
    SFR_OTHER  = 3'h0,
    SFR_FEED1  = 3'h1,
    SFR_FEED2  = 3'h2,
    SFR_CTRL   = 3'h3,
    SFR_RELOAD = 3'h4
  } wft_sfr_t;

  // feed sequence state
  typedef enum logic [0:0] {
    FEED_IDLE  = 1'h0,
    FEED_ARMED = 1'h1
  } wft_feed_t;

endpackage : wft_pkg

// ---- core/wft_watchdog.sv ----
// watchdog feed timer: prescaler, main down-counter and feed sequencer
//
// Behaviour
// R1: watchdog runs after every reset; software must stop it explicitly
// R2: 13-bit prescaler then 8-bit down-counter, clocked by timer clock source
// R3: main counter decremented by a tap from the upper prescaler bits
// R4: fastest tap decrements once every 32 timer clock periods
// R5: decrement at zero signals underflow and reloads from the autoload value
// R6: autoload value 0 to FF allowed; every autoload clears the prescaler
// R7: timeout is tick period times divisor times reload plus one
// R8: counter only loadable from autoload register via a valid feed
// R9: feed is A5 to first register then 5A to second; then autoload
// R10: any other register access between the two feed writes resets
// R11: wrong value to second feed register after armed first resets at once
// R12: control register writes stay pending until the next valid feed
// R13: software stops the watchdog by writing zero then feeding
// R14: underflow triggers a full system reset
// R15: software must feed within one timeout period
// R16: software should mask interrupts around the feed sequence
// R17: three select bits choose divisor 32 up to 4096
// R18: reset sets run, clears reload, flag and prescaler, max divisor, loads
// R19: underflow reloads, sets timeout flag, keeps run, reload and select
// R20: control byte: select bits 7..5, run bit 2, timeout flag bit 1
// R21: first feed write other than A5 leaves the sequence unarmed
`timescale 1ns/1ps
`default_nettype none
`include "wft_consts.svh"

module wft_watchdog (
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic                   timer_tick,
  input  wire logic                   sfr_access,
  input  wire logic                   sfr_wr,
  input  wire wft_pkg::wft_sfr_t      sfr_sel,
  input  wire logic [7:0]             sfr_wdata,
  output logic                        wd_reset,
  output logic                        wd_run_bit,
  output logic                        wd_timeout_flag,
  output logic [2:0]                  prescale_sel,
  output logic [7:0]                  ctrl_pending,
  output logic [7:0]                  wd_reload_value,
  output logic [7:0]                  count_value
);
  import wft_pkg::*;

  typedef struct packed {
    logic [`WFT_PRESC_W-1:0] presc;
    logic [`WFT_COUNT_W-1:0] count;
    logic [7:0]              reload;
    logic [`WFT_SEL_W-1:0]   sel;
    logic                    run;
    logic                    tof;
    logic [7:0]              pend;
    wft_feed_t               fstate;
    logic                    rst_out;
  } wft_state_t;

  wft_state_t st_reg;
  wft_state_t st_next;
  logic       feed_ok;
  logic       feed_bad;
  logic       tap_dec;

  // true when the selected tap bit is about to carry; one decode per tick
  function automatic logic tap_hit(input logic [`WFT_PRESC_W-1:0] p,
                                   input logic [`WFT_SEL_W-1:0]   s);
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < `WFT_PRESC_W; i++) begin
      if (i <= `WFT_TAP_BASE + int'(s)) begin
        hit = hit & p[i];
      end
    end
    return hit;
  endfunction : tap_hit

  // feed sequencer decisions; the access after an armed first write decides
  assign feed_ok = sfr_access && (st_reg.fstate == FEED_ARMED) && sfr_wr
                   && (sfr_sel == SFR_FEED2)
                   && (sfr_wdata == `WFT_FEED2_KEY);          // [R9]
  assign feed_bad = sfr_access && (st_reg.fstate == FEED_ARMED)
                    && !feed_ok;                              // [R10] [R11]
  // divisor is 2**(5+sel) ticks of the timer clock source
  assign tap_dec = st_reg.run && timer_tick
                   && tap_hit(st_reg.presc, st_reg.sel);      // [R3] [R4] [R17]

  // next state
  always_comb begin
    st_next = st_reg;
    st_next.rst_out = 1'b0;
    // arming: only an exact first key arms, anything else disarms
    if (sfr_access) begin
      if (st_reg.fstate == FEED_ARMED) begin
        st_next.fstate = FEED_IDLE;
      end else if (sfr_wr && sfr_sel == SFR_FEED1
                   && sfr_wdata == `WFT_FEED1_KEY) begin
        st_next.fstate = FEED_ARMED;                          // [R21]
      end
    end
    // control writes land in the pending copy; flag clear is immediate
    if (sfr_access && sfr_wr && sfr_sel == SFR_CTRL) begin
      st_next.pend = sfr_wdata;                               // [R12]
      if (!sfr_wdata[`WFT_TOF_BIT]) begin
        st_next.tof = 1'b0;
      end
    end
    // reload is only a source for autoloads, never the counter itself
    if (sfr_access && sfr_wr && sfr_sel == SFR_RELOAD) begin
      st_next.reload = sfr_wdata;                             // [R8]
    end
    if (st_reg.run && timer_tick) begin
      st_next.presc = st_reg.presc + `WFT_PRESC_W'(1);        // [R2]
    end
    // a good feed beats a same-cycle underflow: the software did its job
    if (feed_ok) begin
      st_next.count = st_reg.reload;                          // [R9] [R8]
      st_next.presc = `WFT_PRESC_RST;                         // [R6]
      st_next.sel = st_reg.pend[`WFT_SEL_MSB:`WFT_SEL_LSB];   // [R12] [R20]
      st_next.run = st_reg.pend[`WFT_RUN_BIT];                // [R13]
    end else if (tap_dec) begin
      if (st_reg.count == `WFT_COUNT_W'(0)) begin
        st_next.count = st_reg.reload;                        // [R5] [R19]
        st_next.presc = `WFT_PRESC_RST;                       // [R6] [R7]
        st_next.tof = 1'b1;                                   // [R19]
        st_next.rst_out = 1'b1;                               // [R14]
      end else begin
        st_next.count = st_reg.count - `WFT_COUNT_W'(1);      // [R3]
      end
    end
    // broken sequence forces a reset and marks the watchdog as its cause
    if (feed_bad) begin
      st_next.rst_out = 1'b1;                                 // [R10] [R11]
      st_next.tof = 1'b1;
    end
  end

  // state register; reset loads the counter from the cleared reload
  always_ff @(posedge clock) begin
    if (srst) begin
      st_reg.presc <= `WFT_PRESC_RST;                         // [R18]
      st_reg.count <= `WFT_RELOAD_RST;
      st_reg.reload <= `WFT_RELOAD_RST;
      st_reg.sel <= `WFT_SEL_RST;
      st_reg.run <= 1'b1;                                     // [R1]
      st_reg.tof <= 1'b0;
      st_reg.pend <= `WFT_CTRL_RST;                           // [R20]
      st_reg.fstate <= FEED_IDLE;
      st_reg.rst_out <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs are plain state fields
  assign wd_reset = st_reg.rst_out;
  assign wd_run_bit = st_reg.run;
  assign wd_timeout_flag = st_reg.tof;
  assign prescale_sel = st_reg.sel;
  assign ctrl_pending = st_reg.pend;
  assign wd_reload_value = st_reg.reload;
  assign count_value = st_reg.count;

  // checks on the sequencer, the counter and the control path
  sequence s_armed;
    sfr_access && sfr_wr && sfr_sel == SFR_FEED1
      && sfr_wdata == `WFT_FEED1_KEY && st_reg.fstate == FEED_IDLE;
  endsequence

  sequence s_good_second;
    sfr_access && sfr_wr && sfr_sel == SFR_FEED2
      && sfr_wdata == `WFT_FEED2_KEY;
  endsequence

  property p_feed_loads;
    @(posedge clock) disable iff (srst)
      s_armed ##1 s_good_second |=>
        count_value == $past(st_reg.reload) && st_reg.presc == 13'h0000;
  endproperty
  a_feed_loads: assert property (p_feed_loads) // [R9] [R6]
    else $error("valid feed did not autoload");

  property p_bad_second;
    @(posedge clock) disable iff (srst)
      s_armed ##1 (sfr_access && sfr_wr && sfr_sel == SFR_FEED2
                   && sfr_wdata != `WFT_FEED2_KEY) |=> wd_reset;
  endproperty
  a_bad_second: assert property (p_bad_second) // [R11]
    else $error("wrong second key did not reset");

  property p_intervene;
    @(posedge clock) disable iff (srst)
      s_armed ##1 (sfr_access && sfr_sel != SFR_FEED2) |=>
        wd_reset && wd_timeout_flag;
  endproperty
  a_intervene: assert property (p_intervene) // [R10]
    else $error("intervening access did not reset");

  property p_unarmed;
    @(posedge clock) disable iff (srst)
      st_reg.fstate == FEED_IDLE && sfr_access && sfr_sel == SFR_FEED2
        && !tap_dec |=> !wd_reset && $stable(count_value);
  endproperty
  a_unarmed: assert property (p_unarmed) // [R21] [R8]
    else $error("unarmed second write had an effect");

  property p_underflow;
    @(posedge clock) disable iff (srst)
      tap_dec && count_value == 8'h00 && !feed_ok |=>
        wd_reset && wd_timeout_flag
        && count_value == $past(st_reg.reload)
        && wd_run_bit == $past(wd_run_bit)
        && prescale_sel == $past(prescale_sel);
  endproperty
  a_underflow: assert property (p_underflow) // [R5] [R14] [R19]
    else $error("underflow handling wrong");

  property p_pending;
    @(posedge clock) disable iff (srst)
      sfr_access && sfr_wr && sfr_sel == SFR_CTRL |=>
        $stable(prescale_sel) && $stable(wd_run_bit)
        && ctrl_pending == $past(sfr_wdata);
  endproperty
  a_pending: assert property (p_pending) // [R12]
    else $error("control write took effect without a feed");

  property p_reset_vals;
    @(posedge clock) disable iff (srst)
      $fell(srst) |-> wd_run_bit && prescale_sel == 3'h7
        && count_value == 8'h00 && !wd_timeout_flag && !wd_reset;
  endproperty
  a_reset_vals: assert property (p_reset_vals) // [R1] [R18] [R20]
    else $error("reset values wrong");

  property p_fast_tap;
    @(posedge clock) disable iff (srst)
      timer_tick && wd_run_bit && prescale_sel == 3'h0
        && st_reg.presc[4:0] != 5'h1F |-> !tap_dec;
  endproperty
  a_fast_tap: assert property (p_fast_tap) // [R4] [R17]
    else $error("fastest tap fired early");

  property p_decrement;
    @(posedge clock) disable iff (srst)
      tap_dec && count_value != 8'h00 && !feed_ok && !feed_bad |=>
        count_value == $past(count_value) - 8'h01 && !wd_reset;
  endproperty
  a_decrement: assert property (p_decrement) // [R3] [R2]
    else $error("decrement wrong");

  property p_stopped;
    @(posedge clock) disable iff (srst)
      !wd_run_bit && !feed_ok |=> $stable(count_value) && !wd_reset
        || $past(feed_bad);
  endproperty
  a_stopped: assert property (p_stopped) // [R13]
    else $error("stopped watchdog moved");

  // a feed completed after idle gaps loads and applies the pending byte
  property p_armed_load;
    @(posedge clock) disable iff (srst)
      st_reg.fstate == FEED_ARMED && sfr_access && sfr_wr
        && sfr_sel == SFR_FEED2 && sfr_wdata == `WFT_FEED2_KEY |=>
        count_value == $past(st_reg.reload) && !wd_reset
        && prescale_sel == $past(st_reg.pend[`WFT_SEL_MSB:`WFT_SEL_LSB])
        && wd_run_bit == $past(st_reg.pend[`WFT_RUN_BIT]);
  endproperty
  a_armed_load: assert property (p_armed_load) // [R9] [R12]
    else $error("armed feed did not apply the pending control byte");

  // anything but the exact first key keeps the sequence unarmed
  property p_first_unarmed;
    @(posedge clock) disable iff (srst)
      st_reg.fstate == FEED_IDLE && sfr_access
        && !(sfr_wr && sfr_sel == SFR_FEED1
             && sfr_wdata == `WFT_FEED1_KEY) |=>
        st_reg.fstate == FEED_IDLE;
  endproperty
  a_first_unarmed: assert property (p_first_unarmed) // [R21]
    else $error("wrong first key armed the feed sequence");

  // clearing the flag works unless a same-cycle set wins
  property p_flag_clear;
    @(posedge clock) disable iff (srst)
      sfr_access && sfr_wr && sfr_sel == SFR_CTRL
        && !sfr_wdata[`WFT_TOF_BIT] && !feed_bad
        && !(tap_dec && count_value == 8'h00) |=> !wd_timeout_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) // [R19]
    else $error("timeout flag not cleared by control write");

  property p_flag_keep;
    @(posedge clock) disable iff (srst)
      sfr_access && sfr_wr && sfr_sel == SFR_CTRL
        && sfr_wdata[`WFT_TOF_BIT] && wd_timeout_flag |=> wd_timeout_flag;
  endproperty
  a_flag_keep: assert property (p_flag_keep) // [R19]
    else $error("timeout flag lost on a write that keeps it");

  // prescaler advances by one per tick between autoloads
  property p_presc_step;
    @(posedge clock) disable iff (srst)
      st_reg.run && timer_tick && !feed_ok
        && !(tap_dec && count_value == 8'h00) |=>
        st_reg.presc == $past(st_reg.presc) + 13'h0001;
  endproperty
  a_presc_step: assert property (p_presc_step) // [R2]
    else $error("prescaler did not advance on a tick");

  // a write to the autoload register never reaches the counter directly
  property p_reload_write;
    @(posedge clock) disable iff (srst)
      sfr_access && sfr_wr && sfr_sel == SFR_RELOAD && !tap_dec |=>
        wd_reload_value == $past(sfr_wdata) && $stable(count_value);
  endproperty
  a_reload_write: assert property (p_reload_write) // [R8]
    else $error("reload write touched the counter");

endmodule : wft_watchdog

`default_nettype wire

// ---- verification/wft_cpu_model.sv ----
// cpu side model: special function register accesses
`timescale 1ns/1ps
`default_nettype none

module wft_cpu_model (
  input  wire logic             clock,
  output logic                  sfr_access,
  output logic                  sfr_wr,
  output var wft_pkg::wft_sfr_t sfr_sel,
  output logic [7:0]            sfr_wdata
);
  import wft_pkg::*;

  // bus idle from time zero
  initial begin
    sfr_access = 1'b0;
    sfr_wr     = 1'b0;
    sfr_sel    = SFR_OTHER;
    sfr_wdata  = 8'h00;
  end

  // one access pulse; data inverted after it so stale bytes never match
  task automatic acc(input logic wr, input wft_sfr_t sel,
                     input logic [7:0] d);
    @(posedge clock);
    sfr_access <= 1'b1;
    sfr_wr     <= wr;
    sfr_sel    <= sel;
    sfr_wdata  <= d;
    @(posedge clock);
    sfr_access <= 1'b0;
    sfr_wdata  <= ~d;
  endtask : acc

  // two accesses back to back, strobe held high across both
  task automatic pair(input logic w1, input wft_sfr_t s1,
                      input logic [7:0] d1, input logic w2,
                      input wft_sfr_t s2, input logic [7:0] d2);
    @(posedge clock);
    sfr_access <= 1'b1;
    sfr_wr     <= w1;
    sfr_sel    <= s1;
    sfr_wdata  <= d1;
    @(posedge clock);
    sfr_wr     <= w2;
    sfr_sel    <= s2;
    sfr_wdata  <= d2;
    @(posedge clock);
    sfr_access <= 1'b0;
    sfr_wdata  <= ~d2;
  endtask : pair

  // two keys with nothing between; caller keeps handlers out meanwhile
  task automatic feed();
    pair(1'b1, SFR_FEED1, 8'hA5, 1'b1, SFR_FEED2, 8'h5A);
  endtask : feed

  // clear the run bit, then feed with idle gaps so it takes effect
  task automatic stop();
    acc(1'b1, SFR_CTRL, 8'h00);
    acc(1'b1, SFR_FEED1, 8'hA5);
    acc(1'b1, SFR_FEED2, 8'h5A);
  endtask : stop
endmodule : wft_cpu_model
`default_nettype wire

// ---- verification/wft_watchdog_tb.sv ----
// self-checking bench for the watchdog feed timer
`timescale 1ns/1ps
`default_nettype none

module wft_watchdog_tb;
  import wft_pkg::*;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic       timer_tick = 1'b0;
  logic       sfr_access, sfr_wr, wd_reset, wd_run_bit, wd_timeout_flag;
  wft_sfr_t   sfr_sel;
  logic [2:0] prescale_sel;
  logic [7:0] sfr_wdata, ctrl_pending, wd_reload_value, count_value;
  int         err_total = 0;
  int         n_compared = 0;
  int         rst_seen = 0;

  // 125 MHz
  always #4 clock = ~clock;

  wft_watchdog u_wft_watchdog (.clock(clock), .srst(srst),
    .timer_tick(timer_tick), .sfr_access(sfr_access), .sfr_wr(sfr_wr),
    .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata), .wd_reset(wd_reset),
    .wd_run_bit(wd_run_bit), .wd_timeout_flag(wd_timeout_flag),
    .prescale_sel(prescale_sel), .ctrl_pending(ctrl_pending),
    .wd_reload_value(wd_reload_value), .count_value(count_value));

  wft_cpu_model u_wft_cpu_model (.clock(clock), .sfr_access(sfr_access),
    .sfr_wr(sfr_wr), .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata));

  // count reset pulses; a stuck pulse shows up as too many
  always @(posedge clock) begin
    if (wd_reset === 1'b1) rst_seen <= rst_seen + 1;
  end

  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t ns: %s", $time, m);
    end
  endtask : chk

  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic w(input wft_sfr_t s, input logic [7:0] d);
    u_wft_cpu_model.acc(1'b1, s, d);
  endtask : w

  // cycles to the next reset pulse; edge sampling costs a cycle or two
  task automatic meas(input int e);
    int n;
    int r0;
    n = 0;
    r0 = rst_seen;
    while (rst_seen == r0 && n < 9000) begin
      @(posedge clock);
      n++;
    end
    #1;
    chk(n >= e - 2 && n <= e + 2, "timeout length");
  endtask : meas

  task automatic t_reset();
    chk(wd_run_bit === 1'b1 && wd_reset === 1'b0, "run");
    chk(wd_timeout_flag === 1'b0, "flag");
    chk(prescale_sel === 3'h7 && ctrl_pending === 8'hE4, "ctrl");
    chk(wd_reload_value === 8'h00 && count_value === 8'h00, "ld");
  endtask : t_reset

  // every divisor code with a zero autoload
  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      w(SFR_CTRL, {c[2:0], 5'h04});
      cyc(1);
      chk(prescale_sel === 3'(c + 7), "pending");
      chk(wd_timeout_flag === 1'b0, "flag clear");
      u_wft_cpu_model.feed();
      cyc(1);
      chk(prescale_sel === c[2:0], "select");
      meas(32 << c);
      chk(wd_timeout_flag === 1'b1 && wd_run_bit === 1'b1, "uf");
    end
  endtask : t_codes

  task automatic t_reload();
    w(SFR_RELOAD, 8'h02);
    w(SFR_CTRL, 8'h04);
    cyc(1);
    chk(count_value === 8'h00 && prescale_sel === 3'h7, "direct");
    u_wft_cpu_model.feed();
    cyc(1);
    chk(count_value === 8'h02 && prescale_sel === 3'h0, "load");
    meas(96);
    chk(count_value === 8'h02 && wd_reload_value === 8'h02, "uf");
    w(SFR_RELOAD, 8'hFF);
    w(SFR_CTRL, 8'hE4);
    u_wft_cpu_model.feed();
  endtask : t_reload

  task automatic t_bad();
    int r0;
    w(SFR_RELOAD, 8'h10);
    r0 = rst_seen;
    u_wft_cpu_model.pair(1'b1, SFR_FEED1, 8'hA5, 1'b1, SFR_FEED2, 8'h00);
    cyc(3);
    chk(rst_seen == r0 + 1 && wd_timeout_flag === 1'b1, "key2");
    w(SFR_CTRL, 8'hE6);
    cyc(1);
    chk(wd_timeout_flag === 1'b1, "flag kept");
    u_wft_cpu_model.pair(1'b1, SFR_FEED1, 8'hA5, 1'b0, SFR_OTHER, 8'h00);
    cyc(3);
    chk(rst_seen == r0 + 2, "between");
    w(SFR_FEED1, 8'h11);
    w(SFR_FEED2, 8'h5A);
    cyc(3);
    chk(rst_seen == r0 + 2 && count_value !== 8'h10, "unarmed");
  endtask : t_bad

  // a live counter would underflow in 544 cycles with this autoload
  task automatic t_stop();
    int r0;
    u_wft_cpu_model.stop();
    cyc(1);
    chk(wd_run_bit === 1'b0, "stop");
    r0 = rst_seen;
    cyc(5000);
    chk(rst_seen == r0, "stopped");
  endtask : t_stop

  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    timer_tick <= 1'b1;
    #1;
    t_reset();
    t_codes();
    t_reload();
    t_bad();
    t_stop();
    print_verdict();
  end

  // hang guard, nearly four times the expected run
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
endmodule : wft_watchdog_tb
`default_nettype wire
